// [tb/rps_far_end.sv]
// far-end serializer model driving the receive link inputs
`timescale 1ns/1ps
`default_nettype none
module rps_far_end
    import rps_pkg::*;
(
    input wire logic clk_sys_i,
    output var rps_link_in_t [1:0] link_o
);
    rps_link_in_t base [2];

    initial begin
        link_o = '0;
        base = '{default: '0};
    end

    // levels change only just after an edge
    task automatic hold(input int p, input rps_link_in_t v);
        @(posedge clk_sys_i);
        base[p] = v;
        link_o[p] <= v;
    endtask

    // one-cycle event on top of the held levels, whatever fields ev sets
    task automatic pulse(input int p, input rps_link_in_t ev);
        @(posedge clk_sys_i);
        link_o[p] <= base[p] | ev;
        @(posedge clk_sys_i);
        link_o[p] <= base[p];
    endtask
endmodule
`default_nettype wire

// [tb/rps_regs_test.sv]
// self-checking bench for the receive port status register set
`timescale 1ns/1ps
`default_nettype none
module rps_regs_test;
    import rps_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    rps_reg_req_t req = '0;
    logic [7:0] rdata;
    logic rvalid;
    rps_link_in_t [1:0] link_in;
    rps_link_out_t [1:0] link_out;
    logic [15:0] notes [$];
    logic [15:0] note;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    rps_link_in_t lv;
    rps_link_in_t ev;
    logic [7:0] v;
    logic [7:0] adr [4] = '{ADDR_LINK_ERR, ADDR_DEBUG, ADDR_AEQ2, ADDR_BYPASS};
    logic [7:0] rv [4] = '{LINK_ERR_RST, DEBUG_RST, AEQ2_RST, BYPASS_RST};
    logic [7:0] wm [4] = '{LINK_ERR_WMASK, DEBUG_WMASK, AEQ2_WMASK & 8'hF7, BYPASS_WMASK};

    rps_regs #(.N(2), .TW(24), .EQ_BASE_CYC(24'h000004)) u_rps_regs (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .req_i(req),
        .rdata_o(rdata),
        .rvalid_o(rvalid),
        .link_i(link_in),
        .link_o(link_out)
    );

    rps_far_end u_rps_far_end (
        .clk_sys_i(clk_sys_i),
        .link_o(link_in)
    );

    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req <= '0;
    endtask

    // expected read value noted with a mask of the bits that matter
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back({m, e});
        op(1'b0, a, 8'h00);
    endtask

    task automatic lock_is(input logic e);
        @(posedge clk_sys_i);
        #1;
        check("receiver locked", {7'h00, link_out[0].receiver_locked}, {7'h00, e});
    endtask

    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        if (rvalid === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected read answer", 8'h00, 8'hFF);
            end else begin
                note = notes.pop_front();
                check("read data", rdata & note[15:8], note[7:0]);
            end
        end
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(11));
        lv = '0;
        lv.lock_raw = 1'b1;
        lv.pass = 1'b1;
        lv.link_clk_seen = 1'b1;
        lv.link_expected = 1'b1;
        lv.eq_floor = 4'($urandom);
        u_rps_far_end.hold(0, lv);
        u_rps_far_end.hold(1, lv);
        repeat (1) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], rv[i], 8'hFF);
            op(1'b1, adr[i], 8'hFF);
            rd(adr[i], wm[i], 8'hFF);
            op(1'b1, adr[i], rv[i]);
        end
        op(1'b1, 8'h4F, 8'hFF);
        rd(8'h4F, 8'h00, 8'hFF);
        op(1'b1, ADDR_PORT_SEL, 8'h01);
        v = 8'($urandom);
        op(1'b1, ADDR_BYPASS, v);
        rd(ADDR_STS1, 8'h40, 8'h40);
        rd(ADDR_BYPASS, v, 8'hFF);
        op(1'b1, ADDR_PORT_SEL, 8'h00);
        rd(ADDR_BYPASS, BYPASS_RST, 8'hFF);
        op(1'b1, ADDR_BYPASS, 8'hA7);
        lock_is(1'b1);
        check("manual eq value", {2'b00, link_out[0].eq_value}, 8'h2B);
        check("eq done bypassed", {7'h00, link_out[0].eq_done}, 8'h01);
        op(1'b1, ADDR_BYPASS, BYPASS_RST);
        rd(ADDR_STS1, 8'h03, 8'h47);
        rd(ADDR_STS2, 8'h00, 8'h0E);
        ev = '0;
        ev.crc_fault = 1'b1;
        ev.order_fault = 1'b1;
        u_rps_far_end.pulse(0, ev);
        rd(ADDR_STS1, 8'h2B, 8'hFF);
        rd(ADDR_STS1, 8'h03, 8'hFF);
        ev = '0;
        ev.width_unsteady = 1'b1;
        ev.width_changed = 1'b1;
        ev.coding_fault = 1'b1;
        ev.buffer_overflow = 1'b1;
        ev.total_changed = 1'b1;
        u_rps_far_end.pulse(0, ev);
        rd(ADDR_STS2, STS2_FLAG_MASK, 8'hFF);
        lv.link_clk_seen = 1'b0;
        u_rps_far_end.hold(0, lv);
        rd(ADDR_STS2, 8'h02, 8'hFF);
        lv.link_clk_seen = 1'b1;
        u_rps_far_end.hold(0, lv);
        ev = '0;
        ev.pix_tick = 1'b1;
        ev.link_error = 1'b1;
        repeat (2) u_rps_far_end.pulse(0, ev);
        lock_is(1'b1);
        u_rps_far_end.pulse(0, ev);
        lock_is(1'b0);
        rd(ADDR_STS1, 8'h12, 8'h13);
        op(1'b1, ADDR_LINK_ERR, 8'h23);
        lv.lock_raw = 1'b0;
        u_rps_far_end.hold(0, lv);
        lv.lock_raw = 1'b1;
        u_rps_far_end.hold(0, lv);
        ev.strobe_wait = 1'b1;
        u_rps_far_end.pulse(0, ev);
        lock_is(1'b1);
        ev.strobe_wait = 1'b0;
        u_rps_far_end.pulse(0, ev);
        lock_is(1'b0);
        op(1'b1, ADDR_DEBUG, 8'h81);
        ev = '0;
        ev.return_frame = 1'b1;
        u_rps_far_end.pulse(0, ev);
        #1;
        check("one return error", {7'h00, link_out[0].return_bit_error}, 8'h01);
        check("full strobe range", {7'h00, link_out[0].strobe_full_range}, 8'h01);
        u_rps_far_end.pulse(0, ev);
        #1;
        check("no second error", {7'h00, link_out[0].return_bit_error}, 8'h00);
        // lock is dropped here, so the equalizer steps once per wait period
        v = {2'b00, link_out[0].eq_value};
        repeat (4 << AEQ2_RST[7:5]) @(posedge clk_sys_i);
        #1;
        check("eq step", {2'b00, link_out[0].eq_value}, v + 8'h01);
        repeat (4) @(posedge clk_sys_i);
        end_of_test();
    end
endmodule
`default_nettype wire

// [verilog/rps_link_err.sv]
// link error counter deciding when receiver lock is dropped
`timescale 1ns/1ps
`default_nettype none
module rps_link_err (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic lock_raw_i,
    input wire logic pix_tick_i,
    input wire logic error_i,
    input wire logic ignore_i,
    input wire logic count_en_i,
    input wire logic [3:0] limit_i,
    output logic lock_ok_o
);
    typedef struct packed {
        logic [3:0] cnt;
        logic dropped;
    } rps_lec_state_t;

    rps_lec_state_t st;
    rps_lec_state_t next_st;
    logic hit;

    always_comb begin
        next_st = st;
        hit = pix_tick_i && error_i && !ignore_i;
        if (!lock_raw_i) begin
            next_st = '0;
        end else if (hit && !st.dropped) begin
            if (!count_en_i) begin
                next_st.dropped = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 4'h1;
                if ((st.cnt + 4'h1) >= limit_i) begin
                    next_st.dropped = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lock_ok_o = lock_raw_i && !st.dropped;

    a_single_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (lock_raw_i && hit && !count_en_i) ##1 lock_raw_i |-> !lock_ok_o)
        else $error("lock kept after single error with counting off");
    a_ignore_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (lock_ok_o && ignore_i) ##1 lock_raw_i |-> $stable(st.cnt) && lock_ok_o)
        else $error("error counted during ignored strobe wait");
endmodule
`default_nettype wire

// [verilog/rps_pkg.sv]
// constants and carriers for the receive port status and adaptation registers
// How it works
// - port-select register chooses which receive port copy is read and written
// - status one bit 6 returns the currently selected port number
// - control channel crc fault bit 5 and order fault bit 3 stick, clear on read
// - lock change flag bit 4 sets on any lock change, clears on read
// - parity flag bit 2 follows the parity count compare, cleared with the count
// - bit 0 shows receiver locked, bit 1 shows pass criteria met
// - line width unsteady bit 7 sticks until status two is read
// - line width change bit 6 and line total change bit 0 clear on read
// - link coding fault bit 5 sticks, clears on read
// - buffer overflow bit 4 sticks, clears on read
// - cable fault bit 1 when link expected but no link clock seen
// - wait-ignore bit hides errors during the strobe wait window, reset 1
// - lock drops when error count reaches limit, or on one error if disabled
// - error counter counts on pixel ticks only while its enable bit 4 is set
// - range-disable bit 7 lets strobe adaptation use the full range
// - debug bit 1 injects continuous return errors, bit 0 injects one
// - equalizer waits base time doubled per code step before the next setting
// - first-lock bit restarts equalizer adaptation at first receiver lock
// - restart bit restarts adaptation and clears itself
// - floor enable starts a restarted adaptation from the floor value instead of zero
// - gated lock mode makes receiver lock also wait for equalizer done
// - bypassed equalizer uses manual upper and lower three bit values
// - bypass bit 0 disables adaptive equalization, reset 0
package rps_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
    localparam logic [7:0] ADDR_STS1 = 8'h4D;
    localparam logic [7:0] ADDR_STS2 = 8'h4E;
    localparam logic [7:0] ADDR_LINK_ERR = 8'hB9;
    localparam logic [7:0] ADDR_DEBUG = 8'hD0;
    localparam logic [7:0] ADDR_AEQ2 = 8'hD2;
    localparam logic [7:0] ADDR_BYPASS = 8'hD4;

    localparam logic [7:0] LINK_ERR_RST = 8'h33;
    localparam logic [7:0] DEBUG_RST = 8'h00;
    localparam logic [7:0] AEQ2_RST = 8'h94;
    localparam logic [7:0] BYPASS_RST = 8'h60;
    localparam logic [7:0] LINK_ERR_WMASK = 8'h3F;
    localparam logic [7:0] DEBUG_WMASK = 8'hDF;
    localparam logic [7:0] AEQ2_WMASK = 8'hFC;
    localparam logic [7:0] BYPASS_WMASK = 8'hFF;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int STS1_PORT_NUM = 6;
    localparam int STS1_PARITY = 2;
    localparam int STS1_PASS = 1;
    localparam int STS1_LOCK = 0;
    localparam int STS2_CSI = 3;
    localparam int STS2_FREQ = 2;
    localparam int STS2_CABLE = 1;
    localparam int LEC_WAIT_IGN = 5;
    localparam int LEC_EN = 4;
    localparam int DBG_RANGE_DIS = 7;
    localparam int DBG_SELFTEST = 5;
    localparam int DBG_INJ_CONT = 1;
    localparam int DBG_INJ_ONE = 0;
    localparam int AEQ_FIRST = 4;
    localparam int EQ_ADAPT_RESTART = 3;
    localparam int AEQ_FLOOR = 2;
    localparam int BYP_LOCK_MODE = 4;
    localparam int BYP_DIS = 0;
    // sticky flag bundle: sts1 {crc, lock change, order} and sts2 {7,6,5,4,0}
    localparam logic [7:0] STS1_FLAG_MASK = 8'h38;
    localparam logic [7:0] STS2_FLAG_MASK = 8'hF1;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int EQ_STEP_BASE_PS = 164000000;
    localparam int EQ_STEP_BASE_CYC = (EQ_STEP_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rps_reg_req_t;

    typedef struct packed {
        logic crc_fault;
        logic order_fault;
        logic parity_above;
        logic lock_raw;
        logic pass;
        logic width_unsteady;
        logic width_changed;
        logic total_changed;
        logic coding_fault;
        logic buffer_overflow;
        logic csi_error;
        logic freq_settled;
        logic link_clk_seen;
        logic link_expected;
        logic selftest_active;
        logic pix_tick;
        logic link_error;
        logic strobe_wait;
        logic return_frame;
        logic [3:0] eq_floor;
    } rps_link_in_t;

    typedef struct packed {
        logic receiver_locked;
        logic strobe_full_range;
        logic return_bit_error;
        logic eq_done;
        logic [5:0] eq_value;
    } rps_link_out_t;

    typedef struct packed {
        logic [7:0] link_err;
        logic [7:0] debug;
        logic [7:0] aeq2;
        logic [7:0] bypass;
    } rps_port_cfg_t;

endpackage

// [verilog/rps_rc_flags.sv]
// sticky read-to-clear flag group
`timescale 1ns/1ps
`default_nettype none
module rps_rc_flags #(
    parameter int W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flags_o
);
    typedef struct packed {
        logic [W-1:0] flags;
    } rps_rcf_state_t;

    rps_rcf_state_t st;
    rps_rcf_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.flags = (st.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flags_o = st.flags;

    a_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
        else $error("flag set lost against clear");
    a_clear_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (clr_i != '0 && set_i == '0) |=> ((flags_o & $past(clr_i)) == '0))
        else $error("flag not cleared by read");
endmodule
`default_nettype wire

// [verilog/rps_regs.sv]
// per receive port status and adaptation control register set
`timescale 1ns/1ps
`default_nettype none
module rps_regs
    import rps_pkg::*;
#(
    parameter int N = 2,
    parameter int TW = 24,
    parameter logic [TW-1:0] EQ_BASE_CYC = TW'(EQ_STEP_BASE_CYC)
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire rps_reg_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire rps_link_in_t [N-1:0] link_i,
    output rps_link_out_t [N-1:0] link_o
);
    localparam int SELW = (N > 1) ? $clog2(N) : 1;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SELW-1:0] sel;
        logic [7:0] rdata;
        logic rvalid;
        rps_port_cfg_t [N-1:0] cfg;
        logic [N-1:0] lock_prev;
        logic [N-1:0] lock_seen;
        logic [N-1:0] inj_armed;
        logic [N-1:0] bc_err;
        logic [N-1:0] eq_done;
        logic [N-1:0][5:0] eq;
        logic [N-1:0][TW-1:0] timer;
    } rps_state_t;

    rps_state_t st;
    rps_state_t next_st;

    logic [N-1:0] lock_ok;
    logic [N-1:0] locked;
    logic [N-1:0][7:0] sts1_word;
    logic [N-1:0][7:0] sts2_word;

    // ----------------------------------------------------------------
    // per port lock, flags and status words
    // ----------------------------------------------------------------
    for (genvar p = 0; p < N; p++) begin : g_port
        rps_link_err u_lec (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .lock_raw_i(link_i[p].lock_raw),
            .pix_tick_i(link_i[p].pix_tick),
            .error_i(link_i[p].link_error),
            .ignore_i(st.cfg[p].link_err[LEC_WAIT_IGN] && link_i[p].strobe_wait),
            .count_en_i(st.cfg[p].link_err[LEC_EN]),
            .limit_i(st.cfg[p].link_err[3:0]),
            .lock_ok_o(lock_ok[p])
        );

        // gated mode also waits for equalizer done
        assign locked[p] = lock_ok[p] && (!st.cfg[p].bypass[BYP_LOCK_MODE] || st.eq_done[p]);
    end

    // bit 5 and bit 4 are shared slots in the bundle; split by register below
    logic [N-1:0][7:0] sts1_flags;
    logic [N-1:0][7:0] sts2_flags;
    logic [N-1:0][7:0] s1_set_q;
    logic [N-1:0][7:0] s2_set_q;

    for (genvar p = 0; p < N; p++) begin : g_split
        assign s1_set_q[p] = {2'b00, link_i[p].crc_fault, locked[p] != st.lock_prev[p],
            link_i[p].order_fault, 3'b000};
        assign s2_set_q[p] = {link_i[p].width_unsteady, link_i[p].width_changed,
            link_i[p].coding_fault, link_i[p].buffer_overflow, 3'b000, link_i[p].total_changed};

        rps_rc_flags #(
            .W(8)
        ) u_sts1 (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .set_i(s1_set_q[p]),
            .clr_i(rd_hit(ADDR_STS1, p) ? STS1_FLAG_MASK : 8'h00),
            .flags_o(sts1_flags[p])
        );

        rps_rc_flags #(
            .W(8)
        ) u_sts2 (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .set_i(s2_set_q[p]),
            .clr_i(rd_hit(ADDR_STS2, p) ? STS2_FLAG_MASK : 8'h00),
            .flags_o(sts2_flags[p])
        );

        always_comb begin
            sts1_word[p] = sts1_flags[p] & STS1_FLAG_MASK;
            sts1_word[p][STS1_PORT_NUM] = st.sel[0];
            sts1_word[p][STS1_PARITY] = link_i[p].parity_above;
            sts1_word[p][STS1_PASS] = link_i[p].pass;
            sts1_word[p][STS1_LOCK] = locked[p];
            sts2_word[p] = sts2_flags[p] & STS2_FLAG_MASK;
            sts2_word[p][STS2_CSI] = link_i[p].csi_error;
            sts2_word[p][STS2_FREQ] = link_i[p].freq_settled;
            sts2_word[p][STS2_CABLE] = link_i[p].link_expected && !link_i[p].link_clk_seen;
        end
    end

    // read strobe aimed at one register of the selected port
    function automatic logic rd_hit(input logic [7:0] a, input int p);
        rd_hit = req_i.rd && (req_i.addr == a) && (int'(st.sel) == p);
    endfunction

    // ----------------------------------------------------------------
    // register access, equalizer stepping and error injection
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] rd;
        logic wr_sel;
        logic restart;
        logic [TW-1:0] wait_cyc;
        rd = 8'h00;
        wr_sel = 1'b0;
        restart = 1'b0;
        wait_cyc = '0;
        next_st = st;
        next_st.rvalid = req_i.rd;
        if (req_i.wr && req_i.addr == ADDR_PORT_SEL) begin
            next_st.sel = req_i.wdata[SELW-1:0];
        end
        for (int p = 0; p < N; p++) begin
            wr_sel = req_i.wr && (int'(st.sel) == p);
            next_st.lock_prev[p] = locked[p];
            // self clearing restart, a new write of 1 restarts again
            next_st.cfg[p].aeq2[EQ_ADAPT_RESTART] = 1'b0;
            if (wr_sel) begin
                case (req_i.addr)
                    ADDR_LINK_ERR: next_st.cfg[p].link_err = req_i.wdata & LINK_ERR_WMASK;
                    ADDR_DEBUG: begin
                        next_st.cfg[p].debug = req_i.wdata & DEBUG_WMASK;
                        if (req_i.wdata[DBG_INJ_ONE]) begin
                            next_st.inj_armed[p] = 1'b1;
                        end
                    end
                    ADDR_AEQ2: next_st.cfg[p].aeq2 = req_i.wdata & AEQ2_WMASK;
                    ADDR_BYPASS: next_st.cfg[p].bypass = req_i.wdata & BYPASS_WMASK;
                    default: ;
                endcase
            end
            // back channel error injection, one bit per frame
            next_st.bc_err[p] = 1'b0;
            if (link_i[p].return_frame) begin
                if (st.cfg[p].debug[DBG_INJ_CONT] || st.inj_armed[p]) begin
                    next_st.bc_err[p] = 1'b1;
                    next_st.inj_armed[p] = 1'b0;
                end
            end
            // equalizer adaptation
            wait_cyc = EQ_BASE_CYC << st.cfg[p].aeq2[7:5];
            restart = st.cfg[p].aeq2[EQ_ADAPT_RESTART];
            if (lock_ok[p] && !st.lock_seen[p]) begin
                next_st.lock_seen[p] = 1'b1;
                restart = restart || st.cfg[p].aeq2[AEQ_FIRST];
            end
            if (st.cfg[p].bypass[BYP_DIS]) begin
                next_st.eq[p] = {st.cfg[p].bypass[7:5], st.cfg[p].bypass[3:1]};
                next_st.eq_done[p] = 1'b1;
                next_st.timer[p] = '0;
            end else if (restart) begin
                next_st.eq[p] = st.cfg[p].aeq2[AEQ_FLOOR] ? {2'b00, link_i[p].eq_floor} : 6'h00;
                next_st.eq_done[p] = 1'b0;
                next_st.timer[p] = '0;
            end else if (lock_ok[p]) begin
                next_st.eq_done[p] = 1'b1;
                next_st.timer[p] = '0;
            end else if (st.timer[p] + TW'(1) >= wait_cyc) begin
                next_st.timer[p] = '0;
                next_st.eq_done[p] = 1'b0;
                if (st.eq[p] != 6'h3F) begin
                    next_st.eq[p] = st.eq[p] + 6'h01;
                end
            end else begin
                next_st.timer[p] = st.timer[p] + TW'(1);
                next_st.eq_done[p] = 1'b0;
            end
            // read mux for the selected port
            if (int'(st.sel) == p) begin
                case (req_i.addr)
                    ADDR_PORT_SEL: rd = 8'(st.sel);
                    ADDR_STS1: rd = sts1_word[p];
                    ADDR_STS2: rd = sts2_word[p];
                    ADDR_LINK_ERR: rd = st.cfg[p].link_err;
                    ADDR_DEBUG: begin
                        rd = st.cfg[p].debug;
                        rd[DBG_SELFTEST] = link_i[p].selftest_active;
                    end
                    ADDR_AEQ2: rd = st.cfg[p].aeq2;
                    ADDR_BYPASS: rd = st.cfg[p].bypass;
                    default: rd = 8'h00;
                endcase
            end
        end
        if (req_i.rd) begin
            next_st.rdata = rd;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
            for (int p = 0; p < N; p++) begin
                st.cfg[p] <= '{link_err: LINK_ERR_RST, debug: DEBUG_RST, aeq2: AEQ2_RST, bypass: BYPASS_RST};
            end
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata_o = st.rdata;
    assign rvalid_o = st.rvalid;

    for (genvar p = 0; p < N; p++) begin : g_out
        assign link_o[p].receiver_locked = locked[p];
        assign link_o[p].strobe_full_range = st.cfg[p].debug[DBG_RANGE_DIS];
        assign link_o[p].return_bit_error = st.bc_err[p];
        assign link_o[p].eq_done = st.eq_done[p];
        assign link_o[p].eq_value = st.eq[p];
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_port_number: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (req_i.rd && req_i.addr == ADDR_STS1) |=> rvalid_o && rdata_o[STS1_PORT_NUM] == $past(st.sel[0]))
        else $error("status one port number wrong");
    a_restart_self: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (req_i.wr && req_i.addr == ADDR_AEQ2 && req_i.wdata[EQ_ADAPT_RESTART] && st.sel == '0)
        |=> st.cfg[0].aeq2[EQ_ADAPT_RESTART] ##1 !st.cfg[0].aeq2[EQ_ADAPT_RESTART])
        else $error("restart bit did not self clear");
    a_bypass_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st.cfg[0].bypass[BYP_DIS] |=> st.eq[0] == {$past(st.cfg[0].bypass[7:5]), $past(st.cfg[0].bypass[3:1])})
        else $error("manual equalizer value not applied");
    a_gated_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (st.cfg[0].bypass[BYP_LOCK_MODE] && !st.eq_done[0]) |-> !link_o[0].receiver_locked)
        else $error("lock shown before equalizer done");
endmodule
`default_nettype wire
